// *** hw/acq_block_framer.sv ***
// Purpose: frame acquired segment data into fixed blocks with packet id
// Assumes: one plugin stream per instance; samples arrive as bytes
// Notes:   a block body is built in a buffer, then sent with its id
// Overview of operation
// R1: Segment preamble of tag, converter index, fine count, timestamp first
// R2: Every 16-bit quantity goes out low byte then high byte
// R3: Block opens with two-byte id; top bit selects plugin
// R4: Low 15 id bits count blocks, one up per block
// R5: Sequence zero only on first preamble block of a transmission
// R6: All-ones sequence only on the final sequence-data block
// R7: Sequence wraps from 0x7ffe back to one, never zero
// R8: Converter index byte names last converter used, 0 to 7
// R9: Fine interval count at preamble offsets 6 and 7, low first
// R10: Timestamp as four words, high word first, each low byte first
// R11: Channel 1 bytes, then channel 2, then next segment preamble
// R12: Start sending once one full block of data is acquired
// R13: One padding sample per segment at 200 MS/s and below
// R14: Highest interleaved rate adds 32 extra samples per channel
// R15: Buffer a whole programmed block before sending anything
// R16: Zero-fill partial final preamble and final data blocks
// R17: Receiver may learn block size from first buffer length
// R18: On retry request resend last block with same identifier
// R19: Channel count high byte zero; time-base size follows, low first
// R20: Preamble bytes 2 to 5 carry block size, low byte first
// R21: Preamble byte 6 carries the plugin channel count
// R22: Byte after converter index always zero
`timescale 1ns/1ps
`include "framer_regs.svh"
module acq_block_framer
  import framer_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Configuration
  input  wire logic        plugin_sel,
  input  wire logic [11:0] block_size,
  input  wire logic [7:0]  channel_count,
  input  wire logic [15:0] time_base_block_size,
  input  wire logic        low_rate,
  input  wire logic        interleaved_max,
  // Transmission control
  input  wire logic        start_tx,
  input  wire logic        retry_req,
  // Descriptor bytes of the plugin preamble
  input  wire logic [7:0]  desc_byte,
  input  wire logic        desc_valid,
  input  wire logic        desc_last,
  output logic             desc_ready,
  // Segment information, held while a segment is framed
  input  wire logic        seg_start,
  input  wire logic [2:0]  converter_index,
  input  wire logic [15:0] fine_interval_count,
  input  wire logic [63:0] timestamp,
  input  wire logic [15:0] seg_samples,
  input  wire logic        seg_final,
  output logic             seg_ready,
  // Sample bytes, channel 1 then channel 2
  input  wire logic [7:0]  sample_byte,
  input  wire logic        sample_valid,
  output logic             sample_ready,
  // Outgoing byte stream
  output logic [7:0]       tx_byte,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic             tx_block_end
);

  // Block body store; the id is added at send time
  logic [7:0]  buf_mem [`BLK_BUF_DEPTH];
  phase_t      ph_q, ph_d;
  tx_t         tx_q, tx_d;
  logic [11:0] wr_q, wr_d, rd_q, rd_d, body_len;
  logic [15:0] cnt_q, cnt_d, seg_len_q, seg_len_d;
  logic        ch2_q, ch2_d, final_q, final_d;
  logic        full_q, full_d, last_q, last_d;
  logic [14:0] seq_q, seq_d, sent_seq_q, sent_seq_d;
  logic        sent_last_q, sent_last_d;
  logic [7:0]  bb, tx_byte_q, tx_byte_d;
  logic        wr_en, blk_done, tx_take;

  // Stream byte order of the per-segment preamble, after the id
  function automatic logic [7:0] seg_pre_byte(input logic [5:0] i,
      input logic [2:0] ci, input logic [15:0] fc, input logic [63:0] ts);
    case (i)
      6'h00: seg_pre_byte = 8'(`SEG_TAG);      // R1 R2
      6'h01: seg_pre_byte = 8'(`SEG_TAG >> 8); // R1 R2
      6'h02: seg_pre_byte = {5'h00, ci};     // R8
      6'h03: seg_pre_byte = 8'h00;           // R22
      6'h04: seg_pre_byte = fc[7:0];         // R9
      6'h05: seg_pre_byte = fc[15:8];        // R9
      6'h06: seg_pre_byte = ts[55:48];       // R10
      6'h07: seg_pre_byte = ts[63:56];       // R10
      6'h08: seg_pre_byte = ts[39:32];       // R10
      6'h09: seg_pre_byte = ts[47:40];       // R10
      6'h0a: seg_pre_byte = ts[23:16];       // R10
      6'h0b: seg_pre_byte = ts[31:24];       // R10
      6'h0c: seg_pre_byte = ts[7:0];         // R10
      default: seg_pre_byte = ts[15:8];      // R10
    endcase
  endfunction

  // Fixed head of the plugin preamble, after the id
  function automatic logic [7:0] plug_pre_byte(input logic [5:0] i,
      input logic [11:0] bs, input logic [7:0] nc, input logic [15:0] tb);
    case (i)
      6'h00: plug_pre_byte = bs[7:0];              // R20
      6'h01: plug_pre_byte = {4'h0, bs[11:8]};     // R20
      6'h02: plug_pre_byte = 8'h00;                // R20
      6'h03: plug_pre_byte = 8'h00;                // R20
      6'h04: plug_pre_byte = nc;                   // R21
      6'h05: plug_pre_byte = 8'h00;                // R19
      6'h06: plug_pre_byte = tb[7:0];              // R19 R2
      default: plug_pre_byte = tb[15:8];           // R19 R2
    endcase
  endfunction

  // Next sequence number after a block
  function automatic logic [14:0] seq_next(input logic [14:0] s);
    seq_next = (s == `SEQ_MAX_ORDINARY) ? `SEQ_WRAP_TO : s + 15'h0001; // R7
  endfunction

  // Body holds block size minus the two id bytes
  assign body_len = block_size - 12'h002;
  assign blk_done = wr_en && (wr_q == body_len - 12'h001);
  assign tx_take  = tx_valid && tx_ready;
  assign tx_byte  = tx_byte_q;

  // Handshakes to sources; stall while a full block waits to go
  always_comb begin
    desc_ready   = (ph_q == PH_DESC) && !full_q;
    seg_ready    = (ph_q == PH_SEGPRE) && !full_q
                   && (cnt_q == 16'(`SEG_PRE_BYTES) - 16'h0001);
    sample_ready = (ph_q == PH_DATA) && !full_q
                   && (cnt_q < seg_len_q);
  end

  // Assembly of block bodies, one byte a cycle
  always_comb begin
    ph_d      = ph_q;
    cnt_d     = cnt_q;
    seg_len_d = seg_len_q;
    ch2_d     = ch2_q;
    final_d   = final_q;
    wr_en     = 1'b0;
    bb        = `PAD_BYTE;
    case (ph_q)
      PH_IDLE: begin
        if (start_tx) begin
          ph_d  = PH_PLUG;
          cnt_d = 16'h0000;
        end
      end
      PH_PLUG: begin
        bb    = plug_pre_byte(cnt_q[5:0], block_size, channel_count,
                              time_base_block_size);
        wr_en = !full_q;
        if (wr_en) begin
          cnt_d = cnt_q + 16'h0001;
          if (cnt_q == 16'(`PLUG_PRE_FIXED) - 16'h0001)
            ph_d = PH_DESC;
        end
      end
      PH_DESC: begin
        bb    = desc_byte;
        wr_en = desc_valid && desc_ready;
        if (wr_en && desc_last) begin
          ph_d    = PH_PAD;                // R16
          final_d = 1'b0;
        end
      end
      PH_SEGPRE: begin
        // Segment fields are sampled as the preamble is written
        bb    = seg_pre_byte(cnt_q[5:0], converter_index,
                             fine_interval_count, timestamp);   // R1
        wr_en = seg_start && !full_q;
        if (wr_en) begin
          cnt_d = cnt_q + 16'h0001;
          if (seg_ready) begin
            ph_d      = PH_DATA;
            cnt_d     = 16'h0000;
            ch2_d     = 1'b0;
            final_d   = seg_final;
            // Extra correction samples per channel
            seg_len_d = seg_samples
                        + (low_rate ? 16'h0001 : 16'h0000)      // R13
                        + (interleaved_max ? 16'(`EXTRA_INTERLEAVED >> 1)
                                           : 16'h0000);         // R14
          end
        end
      end
      PH_DATA: begin
        bb    = sample_byte;
        wr_en = sample_valid && sample_ready;
        if (wr_en && cnt_q == seg_len_q - 16'h0001) begin
          cnt_d = 16'h0000;
          ch2_d = !ch2_q;                  // R11
          if (ch2_q)
            ph_d = final_q ? PH_PAD : PH_SEGPRE;  // R11
        end else if (wr_en) begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      PH_PAD: begin
        wr_en = !full_q && (wr_q != 12'h000);    // R16
        if (!full_q && wr_q == 12'h000) begin
          ph_d  = final_q ? PH_IDLE : PH_SEGPRE;
          cnt_d = 16'h0000;
        end
      end
      default: ph_d = PH_IDLE;
    endcase
    if (start_tx && ph_q != PH_IDLE) begin
      ph_d  = PH_PLUG;
      cnt_d = 16'h0000;
    end
  end

  // Buffer fill and block hand-off
  always_comb begin
    wr_d   = wr_q;
    full_d = full_q;
    last_d = last_q;
    if (wr_en) begin
      wr_d = blk_done ? 12'h000 : wr_q + 12'h001;
      if (blk_done) begin
        full_d = 1'b1;                     // R15 R12
        last_d = (ph_d == PH_PAD) && final_d;   // R6
      end
    end
    if (tx_q == TX_BODY && tx_take && rd_q == body_len - 12'h001)
      full_d = 1'b0;
    if (start_tx) begin
      wr_d   = 12'h000;
      full_d = 1'b0;
    end
  end

  // Sender: two id bytes then the buffered body
  always_comb begin
    tx_d         = tx_q;
    rd_d         = rd_q;
    seq_d        = seq_q;
    sent_seq_d   = sent_seq_q;
    sent_last_d  = sent_last_q;
    tx_valid     = 1'b0;
    tx_byte_d    = 8'h00;
    tx_block_end = 1'b0;
    case (tx_q)
      TX_IDLE: begin
        if (full_q) begin
          tx_d        = TX_ID;
          rd_d        = 12'h000;
          sent_seq_d  = last_q ? `SEQ_LAST : seq_q;    // R6 R5
          sent_last_d = last_q;
          seq_d       = seq_next(seq_q);               // R4
        end else if (retry_req && rd_q != 12'h000) begin
          tx_d = TX_ID;                                // R18
          rd_d = 12'h000;
        end
      end
      TX_ID: begin
        tx_valid = 1'b1;
        if (tx_take) begin
          rd_d = rd_q[0] ? 12'h000 : 12'h001;
          if (rd_q[0])
            tx_d = TX_BODY;
        end
      end
      TX_BODY: begin
        tx_valid = 1'b1;
        tx_block_end = (rd_q == body_len - 12'h001);
        if (tx_take) begin
          rd_d = tx_block_end ? 12'h001 : rd_q + 12'h001;
          if (tx_block_end)
            tx_d = TX_IDLE;
        end
      end
      default: tx_d = TX_IDLE;
    endcase
    if (start_tx) begin
      seq_d = `SEQ_FIRST;                              // R5
      tx_d  = TX_IDLE;
      rd_d  = 12'h000;
    end
    // Byte of the next cycle, so the output leaves a flip-flop
    case (tx_d)
      TX_ID:   tx_byte_d = rd_d[0] ? {plugin_sel, sent_seq_d[14:8]}  // R3
                                   : sent_seq_d[7:0];                // R2
      TX_BODY: tx_byte_d = buf_mem[rd_d];
      default: tx_byte_d = 8'h00;
    endcase
  end

  // Body store writes; no reset needed on data words
  always_ff @(posedge clk_sys) begin
    if (wr_en)
      buf_mem[wr_q] <= bb;
  end

  // State registers
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ph_q        <= PH_IDLE;
      tx_q        <= TX_IDLE;
      wr_q        <= 12'h000;
      rd_q        <= 12'h000;
      cnt_q       <= 16'h0000;
      seg_len_q   <= 16'h0000;
      ch2_q       <= 1'b0;
      final_q     <= 1'b0;
      full_q      <= 1'b0;
      last_q      <= 1'b0;
      seq_q       <= `SEQ_FIRST;
      sent_seq_q  <= `SEQ_FIRST;
      sent_last_q <= 1'b0;
      tx_byte_q   <= 8'h00;
    end else begin
      ph_q        <= ph_d;
      tx_q        <= tx_d;
      wr_q        <= wr_d;
      rd_q        <= rd_d;
      cnt_q       <= cnt_d;
      seg_len_q   <= seg_len_d;
      ch2_q       <= ch2_d;
      final_q     <= final_d;
      full_q      <= full_d;
      last_q      <= last_d;
      seq_q       <= seq_d;
      sent_seq_q  <= sent_seq_d;
      sent_last_q <= sent_last_d;
      tx_byte_q   <= tx_byte_d;
    end
  end

endmodule

// *** hw/framer_pkg.sv ***
// Purpose: types for the acquisition block framer
// Assumes: nothing beyond the header of constants
// Notes:   phases of block assembly and of block sending
package framer_pkg;
  typedef enum logic [2:0] {
    PH_IDLE   = 3'b000,
    PH_PLUG   = 3'b001,
    PH_DESC   = 3'b010,
    PH_SEGPRE = 3'b011,
    PH_DATA   = 3'b100,
    PH_PAD    = 3'b101
  } phase_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ID   = 2'b01,
    TX_BODY = 2'b10
  } tx_t;
endpackage

// *** hw/framer_regs.svh ***
// Purpose: constants for the acquisition block framer
// Assumes: byte-wide output stream, 16-bit words sent low byte first
// Notes:   block length and counts are sized in bytes
`ifndef FRAMER_REGS_SVH
`define FRAMER_REGS_SVH
`define SEG_TAG           16'hffff
`define SEQ_FIRST         15'h0000
`define SEQ_WRAP_TO       15'h0001
`define SEQ_MAX_ORDINARY  15'h7ffe
`define SEQ_LAST          15'h7fff
`define SEG_PRE_BYTES     6'h0e
`define PLUG_PRE_FIXED    6'h08
`define PAD_BYTE          8'h00
`define EXTRA_INTERLEAVED 8'h40
`define BLK_BUF_DEPTH     4096
`endif

// *** verification/byte_sink.sv ***
// Purpose: host side sink for the framed byte stream
// Assumes: ready launched just after an edge
// Notes:   slow mode stalls every other cycle
`timescale 1ns/1ps
module byte_sink (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Stream from the framer
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_block_end,
  output logic            tx_ready,
  // Mode and learned block length
  input wire logic        slow,
  output logic [11:0]     first_len
);
  logic [7:0]  got[$];
  logic [11:0] cnt_q;
  logic        seen_q;
  // Collect bytes; size learned from the first whole buffer
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ready  <= 1'b0;
      cnt_q     <= 12'h000;
      seen_q    <= 1'b0;
      first_len <= 12'h000;
    end else begin
      tx_ready <= !slow || !tx_ready;
      if (tx_valid && tx_ready) begin
        got.push_back(tx_byte);
        cnt_q <= tx_block_end ? 12'h000 : cnt_q + 12'h001;
        if (tx_block_end && !seen_q) begin
          first_len <= cnt_q + 12'h001;
          seen_q    <= 1'b1;
        end
      end
    end
  end
endmodule

// *** verification/framer_properties.sv ***
// Purpose: port-level properties of the block framer
// Assumes: one clock domain, byte stream handshake
// Notes:   block position rebuilt from accepted bytes only
`timescale 1ns/1ps
module framer_checker (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  // Watched ports
  input wire logic        plugin_sel,
  input wire logic [11:0] block_size,
  input wire logic        start_tx,
  input wire logic        retry_req,
  input wire logic [7:0]  tx_byte,
  input wire logic        tx_valid,
  input wire logic        tx_ready,
  input wire logic        tx_block_end
);
  logic [11:0] pos_q;
  logic [7:0]  lo_q;
  logic [14:0] prev_q;
  logic        have_q;
  logic        first_q;
  logic        rty_q;
  logic        xfer;
  logic        idx;
  logic [14:0] nseq;
  assign xfer = tx_valid && tx_ready;
  assign idx  = xfer && pos_q == 12'h001;
  assign nseq = {tx_byte[6:0], lo_q};
  // Position and id history; a new transmission forgets the old one
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pos_q   <= 12'h000;
      lo_q    <= 8'h00;
      prev_q  <= 15'h0000;
      have_q  <= 1'b0;
      first_q <= 1'b0;
      rty_q   <= 1'b0;
    end else begin
      if (xfer) pos_q <= tx_block_end ? 12'h000 : pos_q + 12'h001;
      if (xfer && pos_q == 12'h000) lo_q <= tx_byte;
      if (idx) prev_q <= nseq;
      have_q  <= !start_tx && (have_q || idx);
      first_q <= start_tx || (first_q && !idx);
      // A resent block repeats the id it had before
      rty_q   <= !start_tx && (retry_req || (rty_q && !idx));
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  sequence s_stall; tx_valid && !tx_ready; endsequence
  chk_tx_holds: assert property (s_stall |=> tx_valid && $stable(tx_byte)
    && $stable(tx_block_end)) else $error("stalled byte changed");
  chk_end_valid: assert property (tx_block_end |-> tx_valid)
    else $error("block end without valid");
  chk_id_plugin: assert property (idx |-> tx_byte[7] == plugin_sel)
    else $error("id plugin bit wrong");
  chk_block_len: assert property (xfer && tx_block_end
    |-> pos_q == block_size - 12'h001) else $error("block length wrong");
  chk_seq_step: assert property (idx && have_q && !rty_q
    && nseq != 15'h7fff
    && prev_q != 15'h7ffe |-> nseq == prev_q + 15'h0001)
    else $error("sequence not incremented");
  chk_seq_wrap: assert property (idx && have_q && prev_q == 15'h7ffe
    && nseq != 15'h7fff |-> nseq == 15'h0001) else $error("bad wrap");
  chk_first_zero: assert property (idx && !rty_q
    |-> (nseq == 15'h0000) == first_q) else $error("zero sequence misplaced");
  chk_last_final: assert property (idx && have_q && !rty_q
    && prev_q == 15'h7fff |-> first_q) else $error("block after final");
  chk_retry_same: assert property (idx && rty_q
    |-> nseq == prev_q) else $error("retry id changed");
endmodule
bind acq_block_framer framer_checker framer_checker_inst (
  .clk_sys, .sys_rst, .plugin_sel, .block_size, .start_tx, .retry_req,
  .tx_byte,
  .tx_valid, .tx_ready, .tx_block_end
);

// *** verification/tb.sv ***
// Purpose: self-checking bench for the block framer
// Assumes: 16-byte blocks, one final segment of 4 bytes per channel, 5 with the low rate padding sample
// Notes:   expected stream written out byte by byte
`timescale 1ns/1ps
module tb;
  logic        clk_sys, sys_rst, plugin_sel, low_rate, interleaved_max;
  logic        start_tx, retry_req, desc_valid, desc_last, desc_ready;
  logic        seg_start, seg_final, seg_ready, sample_valid, sample_ready;
  logic        tx_valid, tx_ready, tx_block_end, slow;
  logic [7:0]  channel_count, desc_byte, sample_byte, tx_byte;
  logic [11:0] block_size, first_len;
  logic [15:0] time_base_block_size, fine_interval_count, seg_samples;
  logic [2:0]  converter_index;
  logic [63:0] timestamp;
  int          num_errors = 0;
  int          tests_run = 0;
  acq_block_framer acq_block_framer_inst (
    .clk_sys, .sys_rst, .plugin_sel, .block_size, .channel_count,
    .time_base_block_size, .low_rate, .interleaved_max, .start_tx,
    .retry_req, .desc_byte, .desc_valid, .desc_last, .desc_ready,
    .seg_start, .converter_index, .fine_interval_count, .timestamp,
    .seg_samples, .seg_final, .seg_ready, .sample_byte, .sample_valid,
    .sample_ready, .tx_byte, .tx_valid, .tx_ready, .tx_block_end
  );
  byte_sink byte_sink_inst (
    .clk_sys, .sys_rst, .tx_byte, .tx_valid, .tx_block_end, .tx_ready,
    .slow, .first_len
  );
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task final_report;
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task check_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task check_len(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Wait until the sink holds n bytes; running out counts as a mismatch
  task automatic wait_bytes(input int n);
    for (int i = 0; i < 500 && byte_sink_inst.got.size() < n; i++)
      @(posedge clk_sys);
    if (byte_sink_inst.got.size() < n) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time,
               byte_sink_inst.got.size(), n);
    end
  endtask
  // One transmission: plugin preamble, one final segment of n bytes per
  // channel; with rt the final block is asked for once more afterwards
  task automatic run_stream(input logic p, input logic s, input logic lr,
                            input logic rt);
    int         base;
    int         n;
    logic [7:0] e[$];
    logic [7:0] g[$];
    base = byte_sink_inst.got.size();
    n    = lr ? 5 : 4;
    plugin_sel <= p;
    slow       <= s;
    low_rate   <= lr;
    start_tx   <= 1'b1;
    @(posedge clk_sys);
    start_tx <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      desc_byte  <= 8'hd0 + 8'(i);
      desc_valid <= 1'b1;
      desc_last  <= (i == 3);
      do @(posedge clk_sys); while (desc_ready !== 1'b1);
    end
    desc_valid <= 1'b0;
    seg_start  <= 1'b1;
    do @(posedge clk_sys); while (seg_ready !== 1'b1);
    seg_start <= 1'b0;
    for (int i = 0; i < 2 * n; i++) begin
      sample_byte  <= (i < n) ? 8'ha0 + 8'(i) : 8'hb0 + 8'(i - n);
      sample_valid <= 1'b1;
      do @(posedge clk_sys); while (sample_ready !== 1'b1);
    end
    sample_valid <= 1'b0;
    wait_bytes(base + 48);
    // Retry only while the sender is idle and the buffer untouched
    if (rt) begin
      retry_req <= 1'b1;
      @(posedge clk_sys);
      retry_req <= 1'b0;
      wait_bytes(base + 64);
    end
    // Padded descriptor block, full preamble block, padded final block
    e = '{8'h00, {p, 7'h00}, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00,
          8'h34, 8'h12, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'h00, 8'h00,
          8'h01, {p, 7'h00}, 8'hff, 8'hff, 8'h05, 8'h00, 8'h78, 8'h56,
          8'h11, 8'h00, 8'h33, 8'h22, 8'h55, 8'h44, 8'h77, 8'h66};
    e.push_back(8'hff);
    e.push_back({p, 7'h7f});
    for (int i = 0; i < 2 * n; i++)
      e.push_back((i < n) ? 8'ha0 + 8'(i) : 8'hb0 + 8'(i - n));
    while (e.size() < 48)
      e.push_back(8'h00);
    if (rt)
      e = {e, e[32:47]};
    g = byte_sink_inst.got[base:base + e.size() - 1];
    for (int i = 0; i < e.size(); i++) begin
      if (i >= 48) check_byte(g[i], e[i]);
      else if (i % 16 < 2) check_byte(g[i], e[i]);
      else if (i < 16) check_byte(g[i], e[i]);
      else if (i < 32) check_byte(g[i], e[i]);
      else check_byte(g[i], e[i]);
    end
  endtask
  // Plugin A with a prompt receiver
  task t_plugin_a_prompt;
    run_stream(1'b0, 1'b0, 1'b0, 1'b0);
    check_len(first_len, block_size);
  endtask
  // Restart as plugin B, receiver stalling every other cycle
  task t_restart_b_slow;
    run_stream(1'b1, 1'b1, 1'b0, 1'b0);
  endtask
  // Low rate padding sample, then the final block asked for again
  task t_low_rate_retry;
    run_stream(1'b0, 1'b0, 1'b1, 1'b1);
  endtask
  initial begin
    #1000000;
    num_errors++;
    final_report();
  end
  initial begin
    sys_rst = 1'b1;
    {plugin_sel, low_rate, interleaved_max, start_tx, retry_req} = 5'h00;
    {desc_valid, desc_last, seg_start, sample_valid, slow} = 5'h00;
    seg_final = 1'b1;
    channel_count = 8'h02;
    desc_byte = 8'h00;
    sample_byte = 8'h00;
    block_size = 12'h010;
    time_base_block_size = 16'h1234;
    fine_interval_count = 16'h5678;
    seg_samples = 16'h0004;
    converter_index = 3'h5;
    timestamp = 64'h0011223344556677;
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    t_plugin_a_prompt();
    t_restart_b_slow();
    t_low_rate_retry();
    final_report();
  end
endmodule
